// File: pmp_pkg.sv
`default_nettype none
package pmp_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [3:0] PMP_OFS_STATUS = 4'h0;
    localparam logic [3:0] PMP_OFS_IRQ = 4'h4;
    localparam logic [3:0] PMP_OFS_MASK = 4'h8;
    localparam logic [3:0] PMP_OFS_CTRL = 4'hC;

    // Number of debounced carrier inputs and their bit positions.
    localparam int PMP_NIN = 9;
    localparam int PMP_B_SUPPLY_FAULT = 0;
    localparam int PMP_B_RESET_REQ = 1;
    localparam int PMP_B_POWER_BUTTON = 2;
    localparam int PMP_B_SLEEP_REQ = 3;
    localparam int PMP_B_LID_CLOSED = 4;
    localparam int PMP_B_CELL_DEPLETED = 5;
    localparam int PMP_B_CHARGING = 6;
    localparam int PMP_B_CHARGER_DC = 7;
    localparam int PMP_B_TEST_MODE = 8;
    localparam int PMP_B_BUS_ALERT = 9;
    localparam int PMP_NEV = 10;

    // Control register fields.
    localparam int PMP_C_RUN = 0;
    localparam int PMP_C_WDT_EXPIRED = 1;
    localparam int PMP_C_BOARD_RESET = 2;
    localparam int PMP_C_DEB_LSB = 8;
    localparam int PMP_DEB_W = 16;

    // Reset values.
    localparam logic [PMP_DEB_W-1:0] PMP_DEB_RESET = 16'h0010;
    localparam logic [PMP_NEV-1:0] PMP_MASK_RESET = 10'h000;

    // Sequencer timing: supplies settle before the board is released.
    localparam int PMP_SETTLE_NS = 1000;
    localparam int PMP_CLK_NS = 8;
    localparam int PMP_SETTLE_CYC = (PMP_SETTLE_NS + PMP_CLK_NS - 1)
        / PMP_CLK_NS;
    localparam logic [7:0] PMP_SETTLE_LAST = 8'(PMP_SETTLE_CYC - 1);

    typedef enum logic [3:0] {
        PMP_ST_OFF = 4'h1,
        PMP_ST_SETTLE = 4'h2,
        PMP_ST_RUN = 4'h4,
        PMP_ST_STANDBY = 4'h8
    } pmp_state_e;

    // Active-high conditions seen by the sequencer after filtering.
    typedef struct packed {
        logic bus_alert;
        logic test_mode;
        logic charger_dc;
        logic charging;
        logic cell_depleted;
        logic lid_closed;
        logic sleep_req;
        logic power_button;
        logic reset_req;
        logic supply_fault;
    } pmp_cond_s;

    // Avalon-MM slave request.
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } pmp_avl_req_s;

endpackage
`default_nettype wire

// File: pmp_debounce.sv
`default_nettype none
module pmp_debounce
    import pmp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic pin_n_in,
    input wire logic [PMP_DEB_W-1:0] limit_in,
    output logic active_out
);

    logic sync1_q;
    logic sync2_q;
    logic [PMP_DEB_W-1:0] cnt_q;
    logic [PMP_DEB_W-1:0] cnt_d;
    logic active_q;
    logic differs;
    logic settled;

    // Pins idle high by pull-up, so the synchroniser resets to high.
    assign differs = (~sync2_q) != active_q;
    assign settled = differs && (cnt_q >= limit_in);
    assign cnt_d = differs ? cnt_q + 16'h0001 : 16'h0000;
    assign active_out = active_q;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            cnt_q <= 16'h0000;
            active_q <= 1'b0;
        end else begin
            sync1_q <= pin_n_in;
            sync2_q <= sync1_q;
            cnt_q <= settled ? 16'h0000 : cnt_d; // R16
            if (settled) begin
                active_q <= ~sync2_q; // R16
            end
        end
    end

endmodule
`default_nettype wire

// File: pmp_power_pins.sv
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1: Supplies stay off while the carrier signals a supply fault.
// R2: Carrier powers its circuits only after board power-on is asserted.
// R3: Board standby goes low whenever the suspend-to-RAM indication is low; here only once the sequencer has reached the run state.
// R4: A low external reset request resets the module logic; here it only drives the sequencer off, and the registers keep their values.
// R5: Power button is active low, level sensitive and debounced.
// R6: Sleep request is active low, level sensitive and debounced.
// R7: A debounced low lid input means the lid is closed.
// R8: A low cell-depleted input reports a battery-low condition.
// R9: Carrier holds charging low while charging, floats it when done.
// R10: A low charger input reports that charger DC input is present.
// R11: A low test input selects test mode; high means normal operation.
// R12: A low bus alert input is an interrupt request.
// R13: An active-low reset output holds carrier circuits in reset.
// R14: Watchdog output is driven only during runtime, else released.
// R15: Power-management bus data and clock are open drain.
// R16: Inputs are synchronised, then passed after a stable count; bus alert and suspend are only synchronised.
// R17: Reset output stays asserted whenever the module is in reset.
module pmp_power_pins
    import pmp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic input_supply_fault_n_in,
    input wire logic reset_request_n_in,
    input wire logic power_button_n_in,
    input wire logic sleep_request_n_in,
    input wire logic lid_closed_n_in,
    input wire logic cell_depleted_n_in,
    input wire logic charging_n_in,
    input wire logic charger_dc_present_n_in,
    input wire logic test_mode_n_in,
    input wire logic pm_bus_alert_n_in,
    input wire logic suspend_ram_state_n_in,
    input wire logic pm_bus_sda_in,
    input wire logic pm_bus_scl_in,
    input wire logic pm_bus_sda_drive_low_in,
    input wire logic pm_bus_scl_drive_low_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic supplies_enable_out,
    output logic board_power_on_out,
    output logic board_standby_n_out,
    output logic board_reset_n_out,
    output logic watchdog_expired_n_out,
    output logic watchdog_expired_n_oe_out,
    output logic pm_bus_sda_out,
    output logic pm_bus_sda_oe_out,
    output logic pm_bus_scl_out,
    output logic pm_bus_scl_oe_out,
    output logic test_mode_out,
    output logic irq_out
);

    //////////////////////////////////////////////////////////////////////////
    // Input filtering.

    pmp_avl_req_s req;
    pmp_cond_s cond;
    logic [PMP_NIN-1:0] pins_n;
    logic [PMP_NIN-1:0] filt;
    logic alert_s1_q;
    logic alert_s2_q;
    logic [PMP_DEB_W-1:0] deb_limit_q;

    assign req = '{address: avs_address_in, read: avs_read_in,
                   write: avs_write_in, writedata: avs_writedata_in};

    assign pins_n = {test_mode_n_in, charger_dc_present_n_in, charging_n_in,
                     cell_depleted_n_in, lid_closed_n_in, sleep_request_n_in,
                     power_button_n_in, reset_request_n_in, // R4 R5 R6
                     input_supply_fault_n_in};

    // The same filter serves every carrier level input except the bus alert and the suspend indication.
    genvar gi;
    generate
        for (gi = 0; gi < PMP_NIN; gi++) begin : g_deb
            pmp_debounce u_deb (
                .mclk_in(mclk_in),
                .resetn_in(resetn_in),
                .pin_n_in(pins_n[gi]),
                .limit_in(deb_limit_q),
                .active_out(filt[gi])
            );
        end
    endgenerate

    // The alert is an interrupt level and is only synchronised.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            alert_s1_q <= 1'b1;
            alert_s2_q <= 1'b1;
        end else begin
            alert_s1_q <= pm_bus_alert_n_in;
            alert_s2_q <= alert_s1_q;
        end
    end

    assign cond = {~alert_s2_q, filt}; // R12

    //////////////////////////////////////////////////////////////////////////
    // Power sequencer.
    // Supplies come up first; the carrier is released after settling.

    pmp_state_e state_q;
    pmp_state_e state_d;
    logic [7:0] settle_q;
    logic [7:0] settle_d;
    logic supply_ok;
    logic susp_s1_q;
    logic susp_s2_q;
    logic run_q;
    logic wdt_exp_q;
    logic sw_reset_q;

    assign supply_ok = !cond.supply_fault && !cond.reset_req; // R1 R4

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PMP_ST_OFF: begin
                if (supply_ok) begin
                    state_d = PMP_ST_SETTLE;
                end
            end
            PMP_ST_SETTLE: begin
                if (!supply_ok) begin
                    state_d = PMP_ST_OFF;
                end else if (settle_q == PMP_SETTLE_LAST) begin
                    state_d = PMP_ST_RUN;
                end
            end
            PMP_ST_RUN: begin
                if (!supply_ok) begin
                    state_d = PMP_ST_OFF;
                end else if (!susp_s2_q) begin
                    state_d = PMP_ST_STANDBY; // R3
                end
            end
            PMP_ST_STANDBY: begin
                if (!supply_ok) begin
                    state_d = PMP_ST_OFF;
                end else if (susp_s2_q) begin
                    state_d = PMP_ST_RUN;
                end
            end
            default: state_d = PMP_ST_OFF;
        endcase
    end

    assign settle_d = (state_q == PMP_ST_SETTLE) ? settle_q + 8'h01 : 8'h00;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= PMP_ST_OFF;
            settle_q <= 8'h00;
            susp_s1_q <= 1'b1;
            susp_s2_q <= 1'b1;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
            susp_s1_q <= suspend_ram_state_n_in;
            susp_s2_q <= susp_s1_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Registered pin outputs.
    // The bus lines are open drain: the module only ever pulls them low.
    // Their level inputs are not used by this block.

    logic in_reset;
    logic running;

    assign in_reset = (state_d == PMP_ST_OFF) || (state_d == PMP_ST_SETTLE);
    assign running = (state_d == PMP_ST_RUN) && run_q;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            supplies_enable_out <= 1'b0;
            board_power_on_out <= 1'b0;
            board_standby_n_out <= 1'b1;
            board_reset_n_out <= 1'b0;
            watchdog_expired_n_out <= 1'b1;
            watchdog_expired_n_oe_out <= 1'b0;
            pm_bus_sda_out <= 1'b0;
            pm_bus_sda_oe_out <= 1'b0;
            pm_bus_scl_out <= 1'b0;
            pm_bus_scl_oe_out <= 1'b0;
            test_mode_out <= 1'b0;
        end else begin
            supplies_enable_out <= (state_d != PMP_ST_OFF); // R1
            board_power_on_out <= !in_reset; // R2
            board_standby_n_out <= !(state_d == PMP_ST_STANDBY); // R3
            board_reset_n_out <= !in_reset && !sw_reset_q; // R13 R17
            watchdog_expired_n_out <= !wdt_exp_q;
            watchdog_expired_n_oe_out <= running; // R14
            pm_bus_sda_out <= 1'b0; // R15
            pm_bus_sda_oe_out <= pm_bus_sda_drive_low_in; // R15
            pm_bus_scl_out <= 1'b0; // R15
            pm_bus_scl_oe_out <= pm_bus_scl_drive_low_in; // R15
            test_mode_out <= cond.test_mode; // R11
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Events, interrupt and Avalon-MM registers.

    logic [PMP_NEV-1:0] level;
    logic [PMP_NEV-1:0] level_q;
    logic [PMP_NEV-1:0] rise;
    logic [PMP_NEV-1:0] irq_q;
    logic [PMP_NEV-1:0] mask_q;
    logic [31:0] rdata_d;
    logic hit_status;
    logic hit_irq;
    logic hit_mask;
    logic hit_ctrl;
    logic rd_irq;
    logic [31:0] ctrl_rd;
    logic bus_idle_q;
    logic [PMP_NEV-1:0] irq_clr;
    logic [PMP_NEV-1:0] irq_d;

    // Lid, cell, charger and charging levels are reported as status.
    assign level = cond; // R7 R8 R10
    assign rise = level & ~level_q;

    assign hit_status = req.address == PMP_OFS_STATUS;
    assign hit_irq = req.address == PMP_OFS_IRQ;
    assign hit_mask = req.address == PMP_OFS_MASK;
    assign hit_ctrl = req.address == PMP_OFS_CTRL;
    assign rd_irq = req.read && hit_irq && !bus_idle_q;

    assign ctrl_rd = {8'h00, deb_limit_q, 5'h00, sw_reset_q, wdt_exp_q,
                      run_q};
    assign rdata_d = hit_status ? {22'h0, level} :
                     hit_irq ? {22'h0, irq_q} :
                     hit_mask ? {22'h0, mask_q} :
                     hit_ctrl ? ctrl_rd : 32'h0000_0000;

    // A read clears only the bits that it returned, so an event that lands
    // between the data capture and the clear is kept for the next read.
    // A new event also wins over a clearing read in the same cycle.
    assign irq_clr = rd_irq ? avs_readdata_out[PMP_NEV-1:0] : '0;
    assign irq_d = (irq_q & ~irq_clr) | rise;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            level_q <= '0;
            irq_q <= '0;
            irq_out <= 1'b0;
        end else begin
            level_q <= level;
            irq_q <= irq_d;
            irq_out <= |(irq_d & mask_q);
        end
    end

    // Every access is answered one cycle after it is presented.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus_idle_q <= 1'b1;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            bus_idle_q <= !(req.read || req.write) || !bus_idle_q;
            avs_waitrequest_out <= !((req.read || req.write) && bus_idle_q);
            if (req.read && bus_idle_q) begin
                avs_readdata_out <= rdata_d;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mask_q <= PMP_MASK_RESET;
            deb_limit_q <= PMP_DEB_RESET;
            run_q <= 1'b0;
            wdt_exp_q <= 1'b0;
            sw_reset_q <= 1'b0;
        end else if (req.write && !bus_idle_q) begin
            if (hit_mask) begin
                mask_q <= req.writedata[PMP_NEV-1:0];
            end
            if (hit_ctrl) begin
                run_q <= req.writedata[PMP_C_RUN];
                wdt_exp_q <= req.writedata[PMP_C_WDT_EXPIRED];
                sw_reset_q <= req.writedata[PMP_C_BOARD_RESET];
                deb_limit_q <= req.writedata[PMP_C_DEB_LSB +: PMP_DEB_W];
            end
        end
    end

endmodule
`default_nettype wire

// File: pmp_power_pins_chk.sv
`default_nettype none
module pmp_power_pins_chk
    import pmp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic input_supply_fault_n_in,
    input wire logic reset_request_n_in,
    input wire logic suspend_ram_state_n_in,
    input wire logic pm_bus_sda_drive_low_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic supplies_enable_out,
    input wire logic board_power_on_out,
    input wire logic board_standby_n_out,
    input wire logic board_reset_n_out,
    input wire logic watchdog_expired_n_oe_out,
    input wire logic pm_bus_sda_out,
    input wire logic pm_bus_sda_oe_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);
    //////////////////////////////////////////////////////////////////////////
    // Counts how long the carrier has held a fault or reset request.
    logic [5:0] hold_q;
    logic [5:0] hold_d;
    logic held;
    assign held = !input_supply_fault_n_in || !reset_request_n_in;
    assign hold_d = !held ? 6'h00 : (&hold_q) ? hold_q : hold_q + 6'h01;
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hold_q <= 6'h00;
        end else begin
            hold_q <= hold_d;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    fault_hold_a:
        assert property (hold_q >= 6'h28 |-> !board_power_on_out &&
            !board_reset_n_out &&
            (input_supply_fault_n_in || !supplies_enable_out))
        else $error("Board not held off during fault or reset request");
    supply_order_a:
        assert property (board_power_on_out |-> supplies_enable_out)
        else $error("Board power on without supplies");
    release_order_a:
        assert property ($rose(board_reset_n_out) |-> board_power_on_out)
        else $error("Carrier reset released while unpowered");
    supply_rise_a:
        assert property ($rose(supplies_enable_out) |->
            $past(input_supply_fault_n_in, 3))
        else $error("Supplies enabled right after a fault level");
    standby_idle_a:
        assert property (suspend_ram_state_n_in [*8] |-> board_standby_n_out)
        else $error("Standby output low without suspend");
    standby_cause_a:
        assert property ($fell(board_standby_n_out) |->
            !$past(suspend_ram_state_n_in, 3))
        else $error("Standby entered without suspend indication");
    wait_answer_a:
        assert property ($rose(avs_read_in || avs_write_in) |=>
            !avs_waitrequest_out)
        else $error("Bus access not answered after one cycle");
    wait_pulse_a:
        assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("Wait request low for more than one cycle");
    wdt_runtime_a:
        assert property (watchdog_expired_n_oe_out |-> board_power_on_out &&
            supplies_enable_out)
        else $error("Watchdog output driven outside runtime");
    bus_open_drain_a:
        assert property (!pm_bus_sda_out &&
            pm_bus_sda_oe_out == $past(pm_bus_sda_drive_low_in))
        else $error("Bus data line not driven as open drain");
    cover property (!board_standby_n_out);
    cover property ($fell(supplies_enable_out));
    cover property (watchdog_expired_n_oe_out);
endmodule
bind pmp_power_pins pmp_power_pins_chk u_pmp_power_pins_chk (
    .mclk_in, .resetn_in, .input_supply_fault_n_in, .reset_request_n_in,
    .suspend_ram_state_n_in, .pm_bus_sda_drive_low_in, .avs_read_in,
    .avs_write_in, .avs_waitrequest_out, .supplies_enable_out,
    .board_power_on_out, .board_standby_n_out, .board_reset_n_out,
    .watchdog_expired_n_oe_out, .pm_bus_sda_out, .pm_bus_sda_oe_out);
`default_nettype wire

// File: pmp_carrier_model.sv
`default_nettype none
module pmp_carrier_model
    import pmp_pkg::*;
(
    input wire pmp_cond_s pull_in,
    input wire logic board_power_on_in,
    input wire logic sda_oe_in,
    input wire logic sda_pull_in,
    output var pmp_cond_s pin_n_out,
    output logic sda_out,
    output logic powered_out
);
    // Lines are open drain against module pull-ups: released reads high.
    assign pin_n_out = ~pull_in;
    assign sda_out = !(sda_oe_in || sda_pull_in);
    // Ordinary carrier circuits only run behind board power-on.
    assign powered_out = board_power_on_in;
endmodule
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench
    import pmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic suspend_ram_state_n_in = 1'b1;
    logic pm_bus_sda_drive_low_in = 1'b0;
    logic pm_bus_scl_drive_low_in = 1'b0;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h00000000;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out, supplies_enable_out, board_power_on_out;
    logic board_standby_n_out, board_reset_n_out, watchdog_expired_n_out;
    logic watchdog_expired_n_oe_out, pm_bus_sda_out, pm_bus_sda_oe_out;
    logic pm_bus_scl_out, pm_bus_scl_oe_out, test_mode_out, irq_out;
    logic sda_w, sda_pull = 1'b0, powered;
    pmp_cond_s pull = 10'h000;
    pmp_cond_s pin_n;
    int error_cnt = 0;
    int cmp_count = 0;
    int b;
    always #4 mclk_in = ~mclk_in;
    pmp_power_pins u_pmp_power_pins (
        .mclk_in, .resetn_in,
        .input_supply_fault_n_in(pin_n.supply_fault),
        .reset_request_n_in(pin_n.reset_req),
        .power_button_n_in(pin_n.power_button),
        .sleep_request_n_in(pin_n.sleep_req),
        .lid_closed_n_in(pin_n.lid_closed),
        .cell_depleted_n_in(pin_n.cell_depleted),
        .charging_n_in(pin_n.charging),
        .charger_dc_present_n_in(pin_n.charger_dc),
        .test_mode_n_in(pin_n.test_mode),
        .pm_bus_alert_n_in(pin_n.bus_alert),
        .suspend_ram_state_n_in, .pm_bus_sda_in(sda_w),
        .pm_bus_scl_in(!pm_bus_scl_oe_out), .pm_bus_sda_drive_low_in,
        .pm_bus_scl_drive_low_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_readdata_out,
        .avs_waitrequest_out, .supplies_enable_out, .board_power_on_out,
        .board_standby_n_out, .board_reset_n_out, .watchdog_expired_n_out,
        .watchdog_expired_n_oe_out, .pm_bus_sda_out, .pm_bus_sda_oe_out,
        .pm_bus_scl_out, .pm_bus_scl_oe_out, .test_mode_out, .irq_out);
    pmp_carrier_model u_pmp_carrier_model (.pull_in(pull),
        .board_power_on_in(board_power_on_out),
        .sda_oe_in(pm_bus_sda_oe_out), .sda_pull_in(sda_pull),
        .pin_n_out(pin_n), .sda_out(sda_w), .powered_out(powered));
    //////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // One Avalon access; the request is held until waitrequest is low.
    task automatic avl(input logic w, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !w;
        avs_write_in <= w;
        do begin
            @(posedge mclk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 20);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        chk("bus answer", {31'h0, avs_waitrequest_out}, 32'h0);
        if (n >= 20) final_report();
        @(posedge mclk_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        avl(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input string n,
        input logic [31:0] e);
        logic [31:0] q;
        avl(1'b0, a, 32'h00000000, q);
        chk(n, q, e);
    endtask
    task automatic wait_pin(ref logic s, input logic v, input string n);
        int i;
        for (i = 0; i < 400 && s !== v; i++) begin
            @(posedge mclk_in);
        end
        chk(n, {31'h0, s}, {31'h0, v});
        if (s !== v) final_report();
    endtask
    task automatic wait_st(input int k, input logic v);
        logic [31:0] q;
        int i;
        q = 32'h00000000;
        for (i = 0; i < 60; i++) begin
            avl(1'b0, PMP_OFS_STATUS, 32'h00000000, q);
            if (q[k] === v) break;
        end
        chk("status bit", {31'h0, q[k]}, {31'h0, v});
        if (q[k] !== v) final_report();
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge mclk_in);
        chk("reset out", {31'h0, board_reset_n_out}, 32'h0);
        chk("power on", {31'h0, board_power_on_out}, 32'h0);
        resetn_in <= 1'b1;
        wait_pin(board_power_on_out, 1'b1, "power on");
        wait_pin(board_reset_n_out, 1'b1, "reset out");
        chk("supplies", {31'h0, supplies_enable_out}, 32'h1);
        chk("wdt idle", {31'h0, watchdog_expired_n_oe_out}, 32'h0);
        rd(PMP_OFS_MASK, "mask", 32'h00000000);
        rd(PMP_OFS_CTRL, "ctrl", 32'h00001000);
        wr(4'h2, 32'hFFFFFFFF);
        rd(4'h2, "unmapped", 32'h00000000);
        wr(PMP_OFS_STATUS, 32'h000003FF);
        rd(PMP_OFS_STATUS, "status", 32'h00000000);
        wr(PMP_OFS_CTRL, 32'h00001001);
        wait_pin(watchdog_expired_n_oe_out, 1'b1, "wdt drive");
        wr(PMP_OFS_CTRL, 32'h00001003);
        wait_pin(watchdog_expired_n_out, 1'b0, "wdt level");
        wr(PMP_OFS_CTRL, 32'h00001005);
        wait_pin(board_reset_n_out, 1'b0, "soft reset");
        wr(PMP_OFS_CTRL, 32'h00001001);
        wait_pin(board_reset_n_out, 1'b1, "soft reset");
        wr(PMP_OFS_MASK, 32'h000003FC);
        wr(PMP_OFS_IRQ, 32'h00000000);
        rd(PMP_OFS_IRQ, "irq idle", 32'h00000000);
        for (b = PMP_B_POWER_BUTTON; b < PMP_NEV; b++) begin
            pull[b] <= 1'b1;
            wait_st(b, 1'b1);
            wait_pin(irq_out, 1'b1, "irq");
            if (b == PMP_B_TEST_MODE) begin
                chk("test mode", {31'h0, test_mode_out}, 32'h1);
            end
            rd(PMP_OFS_IRQ, "irq event", 32'h1 << b);
            wait_pin(irq_out, 1'b0, "irq clear");
            pull[b] <= 1'b0;
            wait_st(b, 1'b0);
            rd(PMP_OFS_IRQ, "irq release", 32'h00000000);
        end
        chk("test mode", {31'h0, test_mode_out}, 32'h0);
        pull.power_button <= 1'b1;
        repeat (5) @(posedge mclk_in);
        pull.power_button <= 1'b0;
        repeat (40) @(posedge mclk_in);
        rd(PMP_OFS_IRQ, "glitch", 32'h00000000);
        wr(PMP_OFS_MASK, 32'h00000000);
        pull.lid_closed <= 1'b1;
        wait_st(PMP_B_LID_CLOSED, 1'b1);
        chk("masked irq", {31'h0, irq_out}, 32'h0);
        rd(PMP_OFS_IRQ, "lid event", 32'h00000010);
        pull.lid_closed <= 1'b0;
        suspend_ram_state_n_in <= 1'b0;
        wait_pin(board_standby_n_out, 1'b0, "standby");
        suspend_ram_state_n_in <= 1'b1;
        wait_pin(board_standby_n_out, 1'b1, "standby");
        pm_bus_sda_drive_low_in <= 1'b1;
        pm_bus_scl_drive_low_in <= 1'b1;
        wait_pin(pm_bus_sda_oe_out, 1'b1, "sda drive");
        wait_pin(pm_bus_scl_oe_out, 1'b1, "scl drive");
        chk("sda wire", {31'h0, sda_w}, 32'h0);
        chk("sda level", {31'h0, pm_bus_sda_out}, 32'h0);
        chk("scl level", {31'h0, pm_bus_scl_out}, 32'h0);
        sda_pull <= 1'b1;
        pm_bus_sda_drive_low_in <= 1'b0;
        pm_bus_scl_drive_low_in <= 1'b0;
        wait_pin(pm_bus_sda_oe_out, 1'b0, "sda release");
        wait_pin(pm_bus_scl_oe_out, 1'b0, "scl release");
        chk("sda shared", {31'h0, sda_w}, 32'h0);
        sda_pull <= 1'b0;
        pull.supply_fault <= 1'b1;
        wait_pin(supplies_enable_out, 1'b0, "fault");
        wait_pin(board_reset_n_out, 1'b0, "fault reset");
        repeat (40) @(posedge mclk_in);
        chk("carrier", {31'h0, powered}, 32'h0);
        chk("wdt fault", {31'h0, watchdog_expired_n_oe_out}, 32'h0);
        pull.supply_fault <= 1'b0;
        wait_pin(board_power_on_out, 1'b1, "recover");
        pull.reset_req <= 1'b1;
        wait_pin(board_reset_n_out, 1'b0, "request");
        wait_pin(board_power_on_out, 1'b0, "request");
        repeat (40) @(posedge mclk_in);
        pull.reset_req <= 1'b0;
        wait_pin(board_reset_n_out, 1'b1, "request end");
        final_report();
    end
endmodule
`default_nettype wire
